// >>> common/sxfs_pkg.sv
// Shared types and constants for the sign-widen and float state datapath.
// Assumes a 32-bit memory word port and eight 80-bit float data registers.
package sxfs_pkg;
	// ************************************************************
	// Decoded operations
	// ************************************************************
	typedef enum logic [3:0] {
		OP_NONE,
		OP_SIGN_WIDEN_BW,
		OP_SIGN_WIDEN_WL,
		OP_BYTE_TO_LONG_WIDEN,
		OP_FLOAT_MAGNITUDE,
		OP_FLOAT_MULTI_MOVE_STORE_X,
		OP_FLOAT_MULTI_MOVE_LOAD_X,
		OP_FLOAT_MULTI_MOVE_STORE_L,
		OP_FLOAT_MULTI_MOVE_LOAD_L,
		OP_FLOAT_CONTEXT_STORE,
		OP_FLOAT_CONTEXT_LOAD
	} sxfs_op_t;

	typedef enum {ST_IDLE, ST_XFER} sxfs_state_t;
	typedef enum {KIND_FPR, KIND_FCR, KIND_CTX} sxfs_kind_t;

	// ************************************************************
	// Sizes, steps and reset values
	// ************************************************************
	localparam int FP_REGS = 8;
	localparam int FCR_REGS = 3;
	localparam int CTX_WORDS = 4;
	localparam logic [1:0] FPR_LAST_WORD = 2'h2;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	localparam logic [7:0] FCR_LIST_MASK = 8'h07;
	localparam logic [7:0] CTX_LIST = 8'h0f;
	localparam logic [79:0] FPR_RESET = 80'h0;
	localparam logic [31:0] FCR_RESET = 32'h0;
	localparam logic [31:0] CTX_RESET = 32'h0;
endpackage

// >>> rtl/sxfs_exec.sv
// Sign widening, float magnitude, multi-register float moves and float
// context save/restore. Driven by the core sequencer on the same clock.
// Function
// - Sign widening copies the source top bit into the upper result bits; byte to word keeps bits 31:16.
// - Float magnitude writes the source with sign cleared to the target.
// - Multi store writes each listed float register to consecutive words.
// - Multi load fills each listed float data or control register in order.
// - Context save and restore trap instead of running outside supervisor.
// - Context save writes the internal state frame at the given address.
// - Context restore loads the internal state frame from the address.
`timescale 1ns/100ps
`default_nettype none
module sxfs_exec (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// Decoded instruction
	input wire logic op_valid,
	input wire sxfs_pkg::sxfs_op_t op_code,
	input wire logic supervisor,
	input wire logic [31:0] op_data,
	input wire logic [2:0] op_dreg,
	input wire logic [2:0] op_fsrc,
	input wire logic [2:0] op_fdst,
	input wire logic op_fsrc_ext,
	input wire logic [79:0] op_fext,
	input wire logic [7:0] op_list,
	input wire logic op_list_in_dreg,
	input wire logic [31:0] op_addr,
	// Status
	output logic op_ready,
	output logic op_done,
	output logic priv_trap,
	// Data register write
	output logic dreg_we,
	output logic [2:0] dreg_idx,
	output logic [31:0] dreg_wdata,
	// Memory word port
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack
);
	// ************************************************************
	// State
	// ************************************************************
	sxfs_pkg::sxfs_state_t state_reg, state_next;
	sxfs_pkg::sxfs_kind_t kind_reg, kind_next;
	logic [79:0] fpr_reg [sxfs_pkg::FP_REGS];
	logic [79:0] fpr_next [sxfs_pkg::FP_REGS];
	logic [31:0] fcr_reg [sxfs_pkg::FCR_REGS];
	logic [31:0] fcr_next [sxfs_pkg::FCR_REGS];
	logic [31:0] ctx_reg [sxfs_pkg::CTX_WORDS];
	logic [31:0] ctx_next [sxfs_pkg::CTX_WORDS];
	logic [7:0] list_reg, list_next;
	logic [2:0] item_reg, item_next;
	logic [1:0] word_reg, word_next;
	logic done_reg, done_next, trap_reg, trap_next;
	logic dwe_reg, dwe_next;
	logic [2:0] didx_reg, didx_next;
	logic [31:0] dwd_reg, dwd_next;
	logic req_reg, req_next, we_reg, we_next;
	logic [31:0] addr_reg, addr_next, wd_reg, wd_next;
	logic start;
	logic last_word;
	logic [3:0] nx;
	logic [7:0] list_sel;
	logic [79:0] mag_src;

	// Lowest listed index above cur, or the lowest at all when first
	function automatic logic [3:0] sxfs_next_item(input logic [7:0] list,
		input logic [2:0] cur, input logic first);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (list[i] && (first || i > int'(cur))) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	assign start = ce && state_reg == sxfs_pkg::ST_IDLE && op_valid;
	assign op_ready = state_reg == sxfs_pkg::ST_IDLE;
	assign op_done = done_reg;
	assign priv_trap = trap_reg;
	assign dreg_we = dwe_reg;
	assign dreg_idx = didx_reg;
	assign dreg_wdata = dwd_reg;
	assign mem_req = req_reg;
	assign mem_we = we_reg;
	assign mem_addr = addr_reg;
	assign mem_wdata = wd_reg;
	assign last_word = kind_reg != sxfs_pkg::KIND_FPR ||
		word_reg == sxfs_pkg::FPR_LAST_WORD;

	// ************************************************************
	// Next values
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		fpr_next = fpr_reg;
		fcr_next = fcr_reg;
		ctx_next = ctx_reg;
		list_next = list_reg;
		item_next = item_reg;
		word_next = word_reg;
		done_next = 1'b0;
		trap_next = 1'b0;
		dwe_next = 1'b0;
		didx_next = didx_reg;
		dwd_next = dwd_reg;
		req_next = req_reg;
		we_next = we_reg;
		addr_next = addr_reg;
		wd_next = wd_reg;
		nx = 4'h0;
		list_sel = op_list_in_dreg ? op_data[7:0] : op_list;
		mag_src = op_fsrc_ext ? op_fext : fpr_reg[op_fsrc];
		unique case (state_reg)
			sxfs_pkg::ST_IDLE: begin
				if (op_valid) begin
					didx_next = op_dreg;
					addr_next = op_addr;
					unique case (op_code)
						sxfs_pkg::OP_SIGN_WIDEN_BW: begin
							dwe_next = 1'b1;
							dwd_next = {op_data[31:16], {8{op_data[7]}},
								op_data[7:0]};
							done_next = 1'b1;
						end
						sxfs_pkg::OP_SIGN_WIDEN_WL: begin
							dwe_next = 1'b1;
							dwd_next = {{16{op_data[15]}}, op_data[15:0]};
							done_next = 1'b1;
						end
						sxfs_pkg::OP_BYTE_TO_LONG_WIDEN: begin
							dwe_next = 1'b1;
							dwd_next = {{24{op_data[7]}}, op_data[7:0]};
							done_next = 1'b1;
						end
						sxfs_pkg::OP_FLOAT_MAGNITUDE: begin
							fpr_next[op_fdst] = {1'b0, mag_src[78:0]};
							done_next = 1'b1;
						end
						sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_X,
						sxfs_pkg::OP_FLOAT_MULTI_MOVE_LOAD_X: begin
							kind_next = sxfs_pkg::KIND_FPR;
							list_next = list_sel;
							we_next = op_code ==
								sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_X;
						end
						sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_L,
						sxfs_pkg::OP_FLOAT_MULTI_MOVE_LOAD_L: begin
							kind_next = sxfs_pkg::KIND_FCR;
							list_next = list_sel & sxfs_pkg::FCR_LIST_MASK;
							we_next = op_code ==
								sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_L;
						end
						sxfs_pkg::OP_FLOAT_CONTEXT_STORE,
						sxfs_pkg::OP_FLOAT_CONTEXT_LOAD: begin
							kind_next = sxfs_pkg::KIND_CTX;
							list_next = supervisor ? sxfs_pkg::CTX_LIST :
								8'h00;
							trap_next = !supervisor;
							we_next = op_code ==
								sxfs_pkg::OP_FLOAT_CONTEXT_STORE;
						end
						default: begin
							done_next = 1'b1;
						end
					endcase
					if (op_code >= sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_X &&
						op_code <= sxfs_pkg::OP_FLOAT_CONTEXT_LOAD &&
						!trap_next) begin
						nx = sxfs_next_item(list_next, 3'h0, 1'b1);
						item_next = nx[2:0];
						word_next = 2'h0;
						req_next = nx[3];
						done_next = !nx[3];
						state_next = nx[3] ? sxfs_pkg::ST_XFER : state_reg;
					end
				end
			end
			sxfs_pkg::ST_XFER: begin
				if (mem_ack) begin
					if (!we_reg) begin
						unique case (kind_reg)
							sxfs_pkg::KIND_FPR: begin
								if (word_reg == 2'h0) begin
									fpr_next[item_reg][79:64] =
										mem_rdata[31:16];
								end else if (word_reg == 2'h1) begin
									fpr_next[item_reg][63:32] = mem_rdata;
								end else begin
									fpr_next[item_reg][31:0] = mem_rdata;
								end
							end
							sxfs_pkg::KIND_FCR: begin
								fcr_next[item_reg[1:0]] = mem_rdata;
							end
							sxfs_pkg::KIND_CTX: begin
								ctx_next[item_reg[1:0]] = mem_rdata;
							end
						endcase
					end
					addr_next = addr_reg + sxfs_pkg::ADDR_STEP;
					if (!last_word) begin
						word_next = word_reg + 2'h1;
					end else begin
						nx = sxfs_next_item(list_reg, item_reg, 1'b0);
						item_next = nx[2:0];
						word_next = 2'h0;
						req_next = nx[3];
						done_next = !nx[3];
						state_next = nx[3] ? sxfs_pkg::ST_XFER :
							sxfs_pkg::ST_IDLE;
					end
				end
			end
		endcase
		if (req_next && we_next) begin
			unique case (kind_next)
				sxfs_pkg::KIND_FPR: begin
					if (word_next == 2'h0) begin
						wd_next = {fpr_next[item_next][79:64], 16'h0000};
					end else if (word_next == 2'h1) begin
						wd_next = fpr_next[item_next][63:32];
					end else begin
						wd_next = fpr_next[item_next][31:0];
					end
				end
				sxfs_pkg::KIND_FCR: begin
					wd_next = fcr_next[item_next[1:0]];
				end
				sxfs_pkg::KIND_CTX: begin
					wd_next = ctx_next[item_next[1:0]];
				end
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= sxfs_pkg::ST_IDLE;
			kind_reg <= sxfs_pkg::KIND_FPR;
			for (int i = 0; i < sxfs_pkg::FP_REGS; i++) begin
				fpr_reg[i] <= sxfs_pkg::FPR_RESET;
			end
			for (int i = 0; i < sxfs_pkg::FCR_REGS; i++) begin
				fcr_reg[i] <= sxfs_pkg::FCR_RESET;
			end
			for (int i = 0; i < sxfs_pkg::CTX_WORDS; i++) begin
				ctx_reg[i] <= sxfs_pkg::CTX_RESET;
			end
			list_reg <= 8'h00;
			item_reg <= 3'h0;
			word_reg <= 2'h0;
			done_reg <= 1'b0;
			trap_reg <= 1'b0;
			dwe_reg <= 1'b0;
			didx_reg <= 3'h0;
			dwd_reg <= 32'h0;
			req_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= 32'h0;
			wd_reg <= 32'h0;
		end else if (ce) begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			fpr_reg <= fpr_next;
			fcr_reg <= fcr_next;
			ctx_reg <= ctx_next;
			list_reg <= list_next;
			item_reg <= item_next;
			word_reg <= word_next;
			done_reg <= done_next;
			trap_reg <= trap_next;
			dwe_reg <= dwe_next;
			didx_reg <= didx_next;
			dwd_reg <= dwd_next;
			req_reg <= req_next;
			we_reg <= we_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	AST_BYTE_LONG: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && op_code == sxfs_pkg::OP_BYTE_TO_LONG_WIDEN |=> dreg_we &&
		dreg_wdata == {{24{$past(op_data[7])}}, $past(op_data[7:0])})
		else $error("byte to long widen result wrong");
	AST_MAGNITUDE: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && op_code == sxfs_pkg::OP_FLOAT_MAGNITUDE |=>
		fpr_reg[$past(op_fdst)] == {1'b0, $past(mag_src[78:0])})
		else $error("magnitude result wrong");
	AST_CONSECUTIVE: assert property (@(posedge clk_sys) disable iff (!nrst)
		ce && mem_req && mem_ack && !(last_word && !nx[3]) |=>
		mem_req && mem_addr == $past(mem_addr) + sxfs_pkg::ADDR_STEP)
		else $error("transfer address not consecutive");
	AST_CTRL_LOAD: assert property (@(posedge clk_sys) disable iff (!nrst)
		ce && mem_req && mem_ack && !mem_we &&
		kind_reg == sxfs_pkg::KIND_FCR |=>
		fcr_reg[$past(item_reg[1:0])] == $past(mem_rdata))
		else $error("control register load lost");
	AST_USER_TRAP: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && !supervisor && (op_code == sxfs_pkg::OP_FLOAT_CONTEXT_STORE ||
		op_code == sxfs_pkg::OP_FLOAT_CONTEXT_LOAD) |=>
		priv_trap && !mem_req && !op_done ##1 !mem_req)
		else $error("context op ran outside supervisor");
	AST_CTX_SAVE: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && supervisor && op_code == sxfs_pkg::OP_FLOAT_CONTEXT_STORE |=>
		mem_req && mem_we && mem_addr == $past(op_addr) &&
		mem_wdata == ctx_reg[0])
		else $error("context save did not start at address");
	AST_CTX_LOAD: assert property (@(posedge clk_sys) disable iff (!nrst)
		ce && mem_req && mem_ack && !mem_we &&
		kind_reg == sxfs_pkg::KIND_CTX |=>
		ctx_reg[$past(item_reg[1:0])] == $past(mem_rdata))
		else $error("context restore word lost");
endmodule // sxfs_exec
`default_nettype wire

// >>> test/sxfs_exec_bench.sv
// Self-checking bench for sxfs_exec: widen, magnitude, multi moves, context.
// Assumes a 50 MHz core clock; the bench plays a memory with random stalls.
`timescale 1ns/100ps
`default_nettype none
module sxfs_exec_bench;
	logic clk_sys = 0, nrst = 0, ce = 1, op_valid = 0, supervisor = 0;
	sxfs_pkg::sxfs_op_t op_code = sxfs_pkg::OP_NONE;
	logic [31:0] op_data = 32'h0, op_addr = 32'h0, mem_rdata = 32'h0;
	logic [2:0] op_dreg = 3'h0, op_fsrc = 3'h0, op_fdst = 3'h0;
	logic op_fsrc_ext = 0, op_list_in_dreg = 0, mem_ack = 0, trap;
	logic [79:0] op_fext = 80'h0, src;
	logic [7:0] op_list = 8'h0, l;
	logic op_ready, op_done, priv_trap, dreg_we, mem_req, mem_we;
	logic [2:0] dreg_idx;
	logic [31:0] dreg_wdata, mem_addr, mem_wdata;
	logic [31:0] mem [logic [31:0]];
	logic [79:0] fr [8];
	int err_count = 0, n_compared = 0;

	sxfs_exec u_sxfs_exec (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.op_valid(op_valid), .op_code(op_code), .supervisor(supervisor),
		.op_data(op_data), .op_dreg(op_dreg), .op_fsrc(op_fsrc),
		.op_fdst(op_fdst), .op_fsrc_ext(op_fsrc_ext), .op_fext(op_fext),
		.op_list(op_list), .op_list_in_dreg(op_list_in_dreg),
		.op_addr(op_addr), .op_ready(op_ready), .op_done(op_done),
		.priv_trap(priv_trap), .dreg_we(dreg_we), .dreg_idx(dreg_idx),
		.dreg_wdata(dreg_wdata), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack));

	always #10 clk_sys = ~clk_sys;

	// ************************************************************
	// Memory: random stalls, read data scrambled when not acked
	// ************************************************************
	always @(negedge clk_sys) begin : resp
		logic a;
		a = mem_req && ($urandom % 3 != 0);
		mem_ack <= a;
		mem_rdata <= a ? mem[mem_addr] : ~mem_rdata;
	end
	always @(posedge clk_sys) begin
		if (mem_req && mem_ack && mem_we)
			mem[mem_addr] = mem_wdata;
	end

	// ************************************************************
	// Tasks and expectations
	// ************************************************************
	task automatic check(input logic [31:0] seen, exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s %h not %h", $time, msg, seen, exp);
		end
	endtask

	task automatic conclude();
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic issue(input sxfs_pkg::sxfs_op_t op, input logic s);
		int n;
		@(negedge clk_sys);
		op_code = op;
		supervisor = s;
		op_valid = 1;
		@(negedge clk_sys);
		op_valid = 0;
		n = 0;
		// Clock enable drops at random while a transfer is under way
		while (op_done !== 1'b1 && priv_trap !== 1'b1 && n < 300) begin
			check({31'h0, op_ready}, 32'h0, "busy ready");
			ce = 1'($urandom % 4 != 0);
			@(negedge clk_sys);
			n++;
		end
		ce = 1;
		if (n >= 300) begin
			err_count++;
			conclude();
		end
		check({31'h0, op_ready}, 32'h1, "idle ready");
		trap = priv_trap;
	endtask

	task automatic mmove(input sxfs_pkg::sxfs_op_t op, input logic [31:0] a,
			input logic [7:0] m, input logic s);
		op_addr = a;
		op_list_in_dreg = 1'($urandom);
		op_data = {24'($urandom), m};
		op_list = op_list_in_dreg ? ~m : m;
		issue(op, s);
	endtask

	task automatic fill(input logic [31:0] a, input int n, input logic rnd);
		for (int i = 0; i < n; i++)
			mem[a + 32'(4 * i)] = rnd ? $urandom : 32'h5a5a_5a5a;
	endtask

	task automatic chk_store(input logic [31:0] a, input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			if (m[i]) begin
				check(mem[a], {fr[i][79:64], 16'h0}, "word0");
				check(mem[a + 4], fr[i][63:32], "word1");
				check(mem[a + 8], fr[i][31:0], "word2");
				a += 12;
			end
		end
		check(mem[a], 32'h5a5a_5a5a, "past end");
	endtask

	function automatic logic [31:0] widen(input int k, input logic [31:0] d);
		case (k)
			1: return {d[31:16], {8{d[7]}}, d[7:0]};
			2: return {{16{d[15]}}, d[15:0]};
			default: return {{24{d[7]}}, d[7:0]};
		endcase
	endfunction

	initial begin
		void'($urandom(44));
		repeat (5) @(negedge clk_sys);
		nrst = 1;
		for (int i = 0; i < 30; i++) begin
			op_data = i == 0 ? 32'h0000_8080 : i == 1 ? 32'hffff_7f7f : $urandom;
			op_dreg = 3'($urandom);
			issue(sxfs_pkg::sxfs_op_t'(4'(1 + i % 3)), 1'($urandom));
			check(dreg_wdata, widen(1 + i % 3, op_data), "widen");
			check({29'h0, dreg_idx}, {29'h0, op_dreg}, "dreg idx");
			check({31'h0, dreg_we}, 32'h1, "dreg we");
		end
		issue(sxfs_pkg::OP_NONE, 0);
		check({29'h0, trap, dreg_we, op_done}, 32'h1, "no op");
		fill(32'h1000, 24, 1);
		mmove(sxfs_pkg::OP_FLOAT_MULTI_MOVE_LOAD_X, 32'h1000, 8'hff, 1);
		for (int i = 0; i < 8; i++)
			fr[i] = {mem[32'h1000 + 12 * i][31:16], mem[32'h1004 + 12 * i],
				mem[32'h1008 + 12 * i]};
		for (int i = 0; i < 8; i++) begin
			l = i == 0 ? 8'h00 : 8'($urandom);
			fill(32'h3000, 24, 1);
			mmove(sxfs_pkg::OP_FLOAT_MULTI_MOVE_LOAD_X, 32'h3000, l, 0);
			for (int k = 0, a = 32'h3000; k < 8; k++) begin
				if (l[k]) begin
					fr[k] = {mem[a][31:16], mem[a + 4], mem[a + 8]};
					a += 12;
				end
			end
			op_fsrc = 3'($urandom);
			op_fdst = 3'($urandom);
			op_fsrc_ext = 1'($urandom);
			op_fext = {1'b1, 79'({$urandom, $urandom, $urandom})};
			src = op_fsrc_ext ? op_fext : fr[op_fsrc];
			issue(sxfs_pkg::OP_FLOAT_MAGNITUDE, 0);
			fr[op_fdst] = {1'b0, src[78:0]};
			l = i == 1 ? 8'hff : i == 0 ? 8'h00 : 8'($urandom) | 8'(1 << op_fdst);
			fill(32'h2000, 25, 0);
			mmove(sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_X, 32'h2000, l, 0);
			chk_store(32'h2000, l);
		end
		// Mid-run reset clears every float data register
		nrst = 0;
		@(negedge clk_sys);
		nrst = 1;
		for (int k = 0; k < 8; k++)
			fr[k] = sxfs_pkg::FPR_RESET;
		fill(32'h2000, 25, 0);
		mmove(sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_X, 32'h2000, 8'hff, 0);
		chk_store(32'h2000, 8'hff);
		fill(32'h4000, 2, 1);
		fill(32'h5000, 4, 0);
		mmove(sxfs_pkg::OP_FLOAT_MULTI_MOVE_LOAD_L, 32'h4000, 8'h05, 0);
		mmove(sxfs_pkg::OP_FLOAT_MULTI_MOVE_STORE_L, 32'h5000, 8'hff, 0);
		check(mem[32'h5000], mem[32'h4000], "fcr0");
		check(mem[32'h5004], 32'h0, "fcr1");
		check(mem[32'h5008], mem[32'h4004], "fcr2");
		check(mem[32'h500c], 32'h5a5a_5a5a, "fcr end");
		fill(32'h6000, 4, 1);
		fill(32'h6100, 4, 1);
		fill(32'h7000, 5, 0);
		op_addr = 32'h6000;
		issue(sxfs_pkg::OP_FLOAT_CONTEXT_LOAD, 1);
		op_addr = 32'h6100;
		issue(sxfs_pkg::OP_FLOAT_CONTEXT_LOAD, 0);
		check({31'h0, trap}, 32'h1, "load trap");
		op_addr = 32'h7000;
		issue(sxfs_pkg::OP_FLOAT_CONTEXT_STORE, 0);
		check({30'h0, trap, op_done}, 32'h2, "store trap");
		check(mem[32'h7000], 32'h5a5a_5a5a, "trap wrote");
		issue(sxfs_pkg::OP_FLOAT_CONTEXT_STORE, 1);
		for (int k = 0; k < 4; k++)
			check(mem[32'h7000 + 4 * k], mem[32'h6000 + 4 * k], "ctx");
		check(mem[32'h7010], 32'h5a5a_5a5a, "ctx end");
		conclude();
	end
endmodule // sxfs_exec_bench
`default_nettype wire
